/* pkg/uafr_defs.svh */
`ifndef UAFR_DEFS_SVH
`define UAFR_DEFS_SVH

// register byte addresses on the axi4-lite slave
`define UAFR_REG_MODE 8'h00
`define UAFR_REG_DIV 8'h04
`define UAFR_REG_STATUS 8'h08
`define UAFR_REG_MASK 8'h0C
`define UAFR_REG_DATA 8'h10

// mode register fields
`define UAFR_MODE_EN 0
`define UAFR_MODE_CHAR7 1
`define UAFR_MODE_PAR_EN 2
`define UAFR_MODE_PAR_ODD 3
`define UAFR_MODE_TWO_END 4
`define UAFR_MODE_HALF 5
`define UAFR_MODE_RST 6'h00
`define UAFR_DIV_RST 16'h0000

// status and mask fields
`define UAFR_ST_DONE 0
`define UAFR_ST_PERR 1
`define UAFR_ST_FERR 2
`define UAFR_ST_OVR 3

// oversample counts: last tick of a bit and of half a bit
`define UAFR_FULL_LAST 4'hF
`define UAFR_FULL_LAST_HALF 4'h7
`define UAFR_MID_LAST 4'h7
`define UAFR_MID_LAST_HALF 4'h3

// index of the last character bit
`define UAFR_IDX_LAST8 3'h7
`define UAFR_IDX_LAST7 3'h6

// line levels
`define UAFR_LINE_IDLE 1'h1
`define UAFR_LINE_LEAD 1'h0

// axi responses
`define UAFR_RESP_OKAY 2'h0
`define UAFR_RESP_SLVERR 2'h2

`endif

/* pkg/uafr_pkg.sv */
package uafr_pkg;

	// frame position of either end
	typedef enum logic [2:0] {
		FS_IDLE,
		FS_LEAD,
		FS_CHAR,
		FS_CHECK,
		FS_END,
		FS_END2
	} uafr_fsm_e;

	// receiver end state
	typedef struct packed {
		logic sync1; // first synchroniser stage
		logic sync2; // second synchroniser stage
		logic [15:0] divcnt; // clocks to next oversample tick
		logic [3:0] cnt; // oversample ticks within a bit
		logic [2:0] idx; // character bit index
		uafr_fsm_e st; // frame position
		logic [7:0] sh; // character being assembled
		logic perr; // parity result of this frame
		logic [7:0] chr; // last received character
		logic chr_stb; // one-cycle arrival pulse
		logic [5:0] mode; // mode register
		logic [15:0] div; // divider register
		logic [3:0] status; // sticky events
		logic [3:0] mask; // interrupt mask
		logic aw_held; // write address captured
		logic [7:0] awaddr; // captured write address
		logic w_held; // write data captured
		logic [31:0] wdata; // captured write data
		logic [3:0] wstrb; // captured byte enables
		logic bvalid; // write response pending
		logic [1:0] bresp; // write response code
		logic rvalid; // read data pending
		logic [1:0] rresp; // read response code
		logic [31:0] rdata; // read data
	} uafr_rx_s;

	// transmitter end state
	typedef struct packed {
		logic [15:0] divcnt; // clocks to next oversample tick
		logic [3:0] cnt; // oversample ticks within a bit
		logic [2:0] idx; // character bit index
		uafr_fsm_e st; // frame position
		logic [7:0] sh; // character being shifted out
		logic pbit; // check bit of this frame
		logic line; // serial line level
	} uafr_tx_s;

	// check bit giving an odd or even count of ones
	function automatic logic char_parity(input logic [7:0] ch, input logic odd);
		return (^ch) ^ odd;
	endfunction : char_parity

	// byte-lane merge of a write into an old word
	function automatic logic [31:0] strb_merge(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] strb);
		logic [31:0] r;
		r = old_w;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = new_w[i*8 +: 8];
			end
		end
		return r;
	endfunction : strb_merge

endpackage : uafr_pkg

/* pkg/uafr_link_if.sv */
`timescale 1ns/1ps
// single asynchronous serial line, idle high
interface uafr_link_if;
	logic serial_in_pin; // line level, driven by the transmitter end
	modport tx_mp (output serial_in_pin);
	modport rx_mp (input serial_in_pin);
endinterface : uafr_link_if

/* rtl/uafr_tx_end.sv */
`timescale 1ns/1ps
`include "uafr_defs.svh"
// remote transmitter: sends one frame per accepted character
module uafr_tx_end (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [7:0] data_i, // character to send
	input wire logic valid_i, // character offered
	output logic ready_o, // idle, character accepted when valid
	input wire logic char7_i, // seven character bits
	input wire logic par_en_i, // check bit enabled
	input wire logic par_odd_i, // odd parity when set
	input wire logic two_end_i, // two end bits
	input wire logic half_rate_i, // 8 ticks per bit instead of 16
	input wire logic [15:0] div_i, // clocks per oversample tick minus one
	uafr_link_if.tx_mp link
);

	uafr_pkg::uafr_tx_s s; // registered state
	uafr_pkg::uafr_tx_s n; // next state
	logic tick; // oversample tick
	logic bit_end; // last tick of the current bit
	logic [3:0] full_last; // last tick index of a bit
	logic [2:0] idx_last; // last character bit index

	// new character only taken between frames
	assign ready_o = (s.st == uafr_pkg::FS_IDLE);
	assign link.serial_in_pin = s.line;

	// next-state logic
	always_comb begin
		n = s;
		tick = (s.divcnt == 16'h0000);
		full_last = half_rate_i ? `UAFR_FULL_LAST_HALF : `UAFR_FULL_LAST;
		idx_last = char7_i ? `UAFR_IDX_LAST7 : `UAFR_IDX_LAST8;
		bit_end = tick && (s.cnt == full_last);
		n.divcnt = tick ? div_i : s.divcnt - 16'h0001;
		if (tick) begin
			n.cnt = bit_end ? 4'h0 : s.cnt + 4'h1;
		end
		case (s.st)
			uafr_pkg::FS_IDLE: begin
				// start a frame with a single low lead bit
				if (valid_i) begin
					n.sh = char7_i ? {1'b0, data_i[6:0]} : data_i;
					n.pbit = uafr_pkg::char_parity(char7_i ? {1'b0, data_i[6:0]} : data_i,
						par_odd_i);
					n.line = `UAFR_LINE_LEAD;
					n.st = uafr_pkg::FS_LEAD;
					n.cnt = 4'h0;
					n.divcnt = div_i;
				end
			end
			uafr_pkg::FS_LEAD: begin
				// character follows lead, lsb first
				if (bit_end) begin
					n.line = s.sh[0];
					n.idx = 3'h0;
					n.st = uafr_pkg::FS_CHAR;
				end
			end
			uafr_pkg::FS_CHAR: begin
				// seven or eight bits, then check or end
				if (bit_end) begin
					if (s.idx == idx_last) begin
						n.line = par_en_i ? s.pbit : `UAFR_LINE_IDLE;
						n.st = par_en_i ? uafr_pkg::FS_CHECK : uafr_pkg::FS_END;
					end else begin
						n.sh = s.sh >> 1;
						n.line = s.sh[1];
						n.idx = s.idx + 3'h1;
					end
				end
			end
			uafr_pkg::FS_CHECK: begin
				// first end bit after the check bit
				if (bit_end) begin
					n.line = `UAFR_LINE_IDLE;
					n.st = uafr_pkg::FS_END;
				end
			end
			uafr_pkg::FS_END: begin
				// full end bit held so the far sample sees it high
				if (bit_end) begin
					n.st = two_end_i ? uafr_pkg::FS_END2 : uafr_pkg::FS_IDLE;
				end
			end
			uafr_pkg::FS_END2: begin
				// second end bit gives slack for back-to-back frames
				if (bit_end) begin
					n.st = uafr_pkg::FS_IDLE;
				end
			end
			default: begin
				n.st = uafr_pkg::FS_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			s <= '0;
			s.line <= `UAFR_LINE_IDLE;
		end else begin
			s <= n;
		end
	end

endmodule : uafr_tx_end

/* rtl/uafr_rx_end.sv */
`timescale 1ns/1ps
`include "uafr_defs.svh"
// Overview of operation
// - frame opens with one low lead bit
// - character field is seven or eight bits
// - optional odd or even check bit
// - one or two high end bits close frame
// - receiver checks only the first end bit
// - normal mode: sixteen ticks per bit
// - low line at a tick starts synchronisation
// - lead bit sampled at eighth tick
// - later samples every sixteen ticks
// - half rate: eight ticks, sample at fourth
// - half-rate end sample 3.5 to 4.5 ticks late
// - data captured at tick, end bit required
// - two end bits count as one for timing
// - slow sender starts end bit before sample
// - fast sender holds end bit past sample
// - back-to-back senders should use two end bits
module uafr_rx_end (
	input wire logic clock_i,
	input wire logic rst_i,
	uafr_link_if.rx_mp link,
	output logic [7:0] char_o, // last received character
	output logic char_stb_o, // one-cycle pulse per frame
	output logic irq_o, // unmasked sticky event pending
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i
);

	uafr_pkg::uafr_rx_s s; // registered state
	uafr_pkg::uafr_rx_s n; // next state
	logic tick; // oversample tick
	logic bit_in; // synchronised line level
	logic [3:0] full_last; // last tick of a bit
	logic [3:0] mid_last; // tick of the lead-bit sample
	logic [2:0] idx_last; // last character bit index
	logic [3:0] stat_set; // events raised this cycle
	logic [3:0] stat_clr; // write-one-to-clear bits
	logic [31:0] merged; // write data merged with old word

	// handshake outputs straight from state
	assign s_axi_awready_o = !s.aw_held && !s.bvalid;
	assign s_axi_wready_o = !s.w_held && !s.bvalid;
	assign s_axi_arready_o = !s.rvalid;
	assign s_axi_bvalid_o = s.bvalid;
	assign s_axi_bresp_o = s.bresp;
	assign s_axi_rvalid_o = s.rvalid;
	assign s_axi_rresp_o = s.rresp;
	assign s_axi_rdata_o = s.rdata;
	assign char_o = s.chr;
	assign char_stb_o = s.chr_stb;
	assign irq_o = |(s.status & s.mask);

	// next-state logic: line sampler, frame decode, register slave
	always_comb begin
		n = s;
		stat_set = 4'h0;
		stat_clr = 4'h0;
		merged = 32'h0000_0000;
		// only the second stage is read
		n.sync1 = link.serial_in_pin;
		n.sync2 = s.sync1;
		bit_in = s.sync2;
		n.chr_stb = 1'b0;
		// oversample tick from the divider
		tick = (s.divcnt == 16'h0000);
		n.divcnt = tick ? s.div : s.divcnt - 16'h0001;
		// sixteen or eight ticks per bit
		full_last = s.mode[`UAFR_MODE_HALF] ? `UAFR_FULL_LAST_HALF
			: `UAFR_FULL_LAST;
		mid_last = s.mode[`UAFR_MODE_HALF] ? `UAFR_MID_LAST_HALF
			: `UAFR_MID_LAST;
		idx_last = s.mode[`UAFR_MODE_CHAR7] ? `UAFR_IDX_LAST7 : `UAFR_IDX_LAST8;
		case (s.st)
			uafr_pkg::FS_IDLE: begin
				// low level at a tick starts synchronisation
				if (s.mode[`UAFR_MODE_EN] && tick && bit_in == `UAFR_LINE_LEAD) begin
					n.st = uafr_pkg::FS_LEAD;
					n.cnt = 4'h0;
				end
			end
			uafr_pkg::FS_LEAD: begin
				// mid-bit lead sample; high means a glitch
				if (tick) begin
					if (s.cnt == mid_last) begin
						n.cnt = 4'h0;
						n.idx = 3'h0;
						n.perr = 1'b0;
						n.st = (bit_in == `UAFR_LINE_LEAD) ? uafr_pkg::FS_CHAR
							: uafr_pkg::FS_IDLE;
					end else begin
						n.cnt = s.cnt + 4'h1;
					end
				end
			end
			uafr_pkg::FS_CHAR: begin
				// one sample per bit period, lsb first
				if (tick) begin
					if (s.cnt == full_last) begin
						n.cnt = 4'h0;
						n.idx = s.idx + 3'h1;
						n.sh = {bit_in, s.sh[7:1]};
						if (s.idx == idx_last) begin
							// seven-bit characters land right-aligned
							if (s.mode[`UAFR_MODE_CHAR7]) begin
								n.sh = {1'b0, bit_in, s.sh[7:2]};
							end
							n.st = s.mode[`UAFR_MODE_PAR_EN] ? uafr_pkg::FS_CHECK
								: uafr_pkg::FS_END;
						end
					end else begin
						n.cnt = s.cnt + 4'h1;
					end
				end
			end
			uafr_pkg::FS_CHECK: begin
				// compare check bit with selected parity
				if (tick) begin
					if (s.cnt == full_last) begin
						n.cnt = 4'h0;
						n.perr = uafr_pkg::char_parity(s.sh,
							s.mode[`UAFR_MODE_PAR_ODD]) != bit_in;
						n.st = uafr_pkg::FS_END;
					end else begin
						n.cnt = s.cnt + 4'h1;
					end
				end
			end
			uafr_pkg::FS_END: begin
				// only the first end bit is checked; back to idle at once
				if (tick) begin
					if (s.cnt == full_last) begin
						n.cnt = 4'h0;
						n.chr = s.sh;
						n.chr_stb = 1'b1;
						stat_set[`UAFR_ST_DONE] = 1'b1;
						stat_set[`UAFR_ST_PERR] = s.perr;
						stat_set[`UAFR_ST_FERR] = (bit_in == `UAFR_LINE_LEAD);
						stat_set[`UAFR_ST_OVR] = s.status[`UAFR_ST_DONE];
						n.st = uafr_pkg::FS_IDLE;
					end else begin
						n.cnt = s.cnt + 4'h1;
					end
				end
			end
			default: begin
				n.st = uafr_pkg::FS_IDLE;
			end
		endcase
		// disabling abandons any frame in progress
		if (!s.mode[`UAFR_MODE_EN]) begin
			n.st = uafr_pkg::FS_IDLE;
		end
		// write address and data taken in either order
		if (s_axi_awvalid_i && s_axi_awready_o) begin
			n.aw_held = 1'b1;
			n.awaddr = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && s_axi_wready_o) begin
			n.w_held = 1'b1;
			n.wdata = s_axi_wdata_i;
			n.wstrb = s_axi_wstrb_i;
		end
		// perform the write once both halves are held
		if (s.aw_held && s.w_held) begin
			n.aw_held = 1'b0;
			n.w_held = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = `UAFR_RESP_OKAY;
			if (s.awaddr == `UAFR_REG_MODE) begin
				merged = uafr_pkg::strb_merge({26'h0, s.mode}, s.wdata, s.wstrb);
				n.mode = merged[5:0];
			end else if (s.awaddr == `UAFR_REG_DIV) begin
				merged = uafr_pkg::strb_merge({16'h0, s.div}, s.wdata, s.wstrb);
				n.div = merged[15:0];
			end else if (s.awaddr == `UAFR_REG_STATUS) begin
				merged = uafr_pkg::strb_merge(32'h0, s.wdata, s.wstrb);
				stat_clr = merged[3:0];
			end else if (s.awaddr == `UAFR_REG_MASK) begin
				merged = uafr_pkg::strb_merge({28'h0, s.mask}, s.wdata, s.wstrb);
				n.mask = merged[3:0];
			end else if (s.awaddr == `UAFR_REG_DATA) begin
				n.bresp = `UAFR_RESP_OKAY;
			end else begin
				n.bresp = `UAFR_RESP_SLVERR;
			end
		end
		if (s.bvalid && s_axi_bready_i) begin
			n.bvalid = 1'b0;
		end
		// read data captured when the address is taken
		if (s_axi_arvalid_i && s_axi_arready_o) begin
			n.rvalid = 1'b1;
			n.rresp = `UAFR_RESP_OKAY;
			if (s_axi_araddr_i == `UAFR_REG_MODE) begin
				n.rdata = {26'h0, s.mode};
			end else if (s_axi_araddr_i == `UAFR_REG_DIV) begin
				n.rdata = {16'h0, s.div};
			end else if (s_axi_araddr_i == `UAFR_REG_STATUS) begin
				n.rdata = {28'h0, s.status};
			end else if (s_axi_araddr_i == `UAFR_REG_MASK) begin
				n.rdata = {28'h0, s.mask};
			end else if (s_axi_araddr_i == `UAFR_REG_DATA) begin
				n.rdata = {24'h0, s.chr};
			end else begin
				n.rdata = 32'h0000_0000;
				n.rresp = `UAFR_RESP_SLVERR;
			end
		end else if (s.rvalid && s_axi_rready_i) begin
			n.rvalid = 1'b0;
		end
		// a new event wins over a clear in the same cycle
		n.status = (s.status & ~stat_clr) | stat_set;
	end

	// state register
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			s <= '0;
			s.sync1 <= `UAFR_LINE_IDLE;
			s.sync2 <= `UAFR_LINE_IDLE;
			s.mode <= `UAFR_MODE_RST;
			s.div <= `UAFR_DIV_RST;
		end else begin
			s <= n;
		end
	end

endmodule : uafr_rx_end

/* tb/uafr_link_chk.sv */
`timescale 1ns/1ps
// watches the serial link and the user sides of the pair
module uafr_link_chk (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic serial_in_pin,
	input wire logic valid_i,
	input wire logic ready_o,
	input wire logic [7:0] data_i,
	input wire logic char7_i,
	input wire logic par_en_i,
	input wire logic par_odd_i,
	input wire logic two_end_i,
	input wire logic half_rate_i,
	input wire logic [15:0] div_i,
	input wire logic char_stb_o,
	input wire logic [7:0] char_o
);
	logic [7:0] d_q; // character of the frame under way
	logic [31:0] fcnt; // clocks since the lead bit began
	logic [31:0] blen; // clocks per bit
	logic [31:0] nbit; // bits on the line in this frame
	logic [31:0] nend; // bits counted for timing
	logic [7:0] dm; // character as it goes on the line
	logic exp_bit; // level the line should show now
	int k; // bit position within the frame
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// frame capture and clock count
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			fcnt <= '0;
			d_q <= '0;
		end else if (valid_i && ready_o) begin
			fcnt <= '0;
			d_q <= data_i;
		end else if (!ready_o) begin
			fcnt <= fcnt + 1;
		end
	end
	// reference frame built from the configuration
	always_comb begin
		blen = (32'(div_i) + 1) * (half_rate_i ? 32'd8 : 32'd16);
		dm = char7_i ? {1'b0, d_q[6:0]} : d_q;
		nbit = (char7_i ? 32'd9 : 32'd10) + 32'(par_en_i) + 32'(two_end_i);
		nend = nbit - 32'(two_end_i);
		k = int'(fcnt / blen);
		if (k == 0) begin
			exp_bit = 1'b0; // lead bit
		end else if (k <= (char7_i ? 7 : 8)) begin
			exp_bit = dm[k-1]; // character, lsb first
		end else if (par_en_i && k == (char7_i ? 8 : 9)) begin
			exp_bit = ^dm ^ par_odd_i; // check bit
		end else begin
			exp_bit = 1'b1; // end bits
		end
	end
	chk_lead_after_take: assert property (
		valid_i && ready_o |=> !serial_in_pin && !ready_o)
		else $error("no lead bit after a taken character");
	chk_line_level: assert property (
		!ready_o |-> serial_in_pin == exp_bit)
		else $error("line level differs from the frame");
	chk_idle_high: assert property (ready_o |-> serial_in_pin)
		else $error("line low outside a frame");
	chk_bit_hold: assert property (
		!ready_o && fcnt % blen != 0 |-> $stable(serial_in_pin))
		else $error("line moved inside a bit period");
	chk_frame_end: assert property (!ready_o && fcnt == nbit * blen - 1 |=> ready_o)
		else $error("frame not closed on time");
	chk_frame_busy: assert property (!ready_o && fcnt < nbit * blen - 1 |=> !ready_o)
		else $error("frame closed early");
	chk_end_sample: assert property (
		char_stb_o |-> !ready_o && fcnt >= (nend - 1) * blen && fcnt < nend * blen)
		else $error("arrival outside the first end bit");
	chk_stb_pulse: assert property (char_stb_o |=> !char_stb_o)
		else $error("arrival pulse longer than a cycle");
	chk_char_value: assert property (char_stb_o |=> char_o == dm)
		else $error("received character differs");
	// main scenarios reached
	cover property (valid_i && ready_o && half_rate_i);
	cover property (char_stb_o && two_end_i);
	cover property (char_stb_o && par_en_i && char7_i);
endmodule : uafr_link_chk

/* tb/test_uart_async_frame_receiver.sv */
`timescale 1ns/1ps
`include "uafr_defs.svh"
// drives the transmitter and two receivers, one fed by a rule-breaking driver
module test_uart_async_frame_receiver;
	localparam int BT = 32; // clocks per bit at divider 1
	logic clock_i = 1'b0; // 250 MHz clock
	logic rst_i = 1'b1; // synchronous reset
	logic [7:0] data; // character offered to the transmitter
	logic valid; // character offer
	logic tx_ready; // transmitter idle
	logic [4:0] cfg; // half, two end, odd, parity, char7
	logic [15:0] div = 16'h0001; // oversample divider
	logic [7:0] awaddr, araddr; // register addresses
	logic [31:0] wdata; // write data
	logic awvalid, wvalid, bready, arvalid, rready; // master handshakes
	logic awrd[2], wrd[2], bv[2], ard[2], rv[2], stb[2], irq[2]; // slave flags
	logic [1:0] bresp[2], rresp[2]; // response codes
	logic [31:0] rdata[2]; // read data
	logic [7:0] chr[2]; // received characters
	int errors = 0; // mismatches
	int n_tests = 0; // comparisons
	logic [4:0] cfgs[6] = '{5'h00, 5'h03, 5'h0E, 5'h17, 5'h1A, 5'h10}; // frame formats
	logic [7:0] chs[6] = '{8'hA5, 8'hDA, 8'h3C, 8'hFF, 8'h01, 8'h80}; // characters
	uafr_link_if lnk[2] (); // design link and faulty link
	// clock
	always #2 clock_i = ~clock_i;
	uafr_tx_end uafr_tx_end_inst (.clock_i(clock_i), .rst_i(rst_i), .data_i(data), .valid_i(valid),
		.ready_o(tx_ready), .char7_i(cfg[0]), .par_en_i(cfg[1]), .par_odd_i(cfg[2]),
		.two_end_i(cfg[3]), .half_rate_i(cfg[4]), .div_i(div), .link(lnk[0]));
	// two receivers sharing the register bus inputs
	for (genvar g = 0; g < 2; g++) begin : g_rx
		uafr_rx_end uafr_rx_end_inst (.clock_i(clock_i), .rst_i(rst_i), .link(lnk[g]),
			.char_o(chr[g]), .char_stb_o(stb[g]), .irq_o(irq[g]), .s_axi_awaddr_i(awaddr),
			.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awrd[g]), .s_axi_wdata_i(wdata),
			.s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wrd[g]),
			.s_axi_bresp_o(bresp[g]), .s_axi_bvalid_o(bv[g]), .s_axi_bready_i(bready),
			.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(ard[g]),
			.s_axi_rdata_o(rdata[g]), .s_axi_rresp_o(rresp[g]), .s_axi_rvalid_o(rv[g]),
			.s_axi_rready_i(rready));
	end
	uafr_link_chk uafr_link_chk_inst (.clock_i(clock_i), .rst_i(rst_i),
		.serial_in_pin(lnk[0].serial_in_pin), .valid_i(valid), .ready_o(tx_ready), .data_i(data),
		.char7_i(cfg[0]), .par_en_i(cfg[1]), .par_odd_i(cfg[2]), .two_end_i(cfg[3]),
		.half_rate_i(cfg[4]), .div_i(div), .char_stb_o(stb[0]), .char_o(chr[0]));
	// verdict and end of run
	task automatic end_sim;
		$display("errors %0d comparisons %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	// a wait ran out
	task automatic tmo;
		errors++;
		end_sim();
	endtask : tmo
	// word compare
	task automatic cmp32(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp32
	// flag compare
	task automatic cmp1(input string nm, input logic e, input logic g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %b seen %b", nm, e, g);
		end
	endtask : cmp1
	// register write, address and data offered together
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int i;
		logic [2:0] hs;
		logic [1:0] rs;
		@(posedge clock_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(negedge clock_i);
			hs = {awvalid & awrd[0], wvalid & wrd[0], bv[0]};
			rs = bresp[0];
			@(posedge clock_i);
			if (hs[2]) awvalid <= 1'b0;
			if (hs[1]) wvalid <= 1'b0;
			if (hs[0]) break;
		end
		bready <= 1'b0;
		if (i == 100) tmo();
		cmp32("bresp", {30'h0, er}, {30'h0, rs});
	endtask : axw
	// register read from receiver s
	task automatic axr(input string nm, input int s, input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		int i;
		logic [1:0] hs;
		logic [31:0] dt;
		logic [1:0] rs;
		@(posedge clock_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(negedge clock_i);
			hs = {arvalid & ard[0], rv[0]};
			dt = rdata[s];
			rs = rresp[s];
			@(posedge clock_i);
			if (hs[1]) arvalid <= 1'b0;
			if (hs[0]) break;
		end
		rready <= 1'b0;
		if (i == 100) tmo();
		cmp32(nm, e, dt);
		cmp32("rresp", {30'h0, er}, {30'h0, rs});
	endtask : axr
	// offer one character, then wait for the frame to finish
	task automatic send(input logic [7:0] d);
		int i;
		logic h;
		@(posedge clock_i);
		data <= d;
		valid <= 1'b1;
		for (i = 0; i < 3000; i++) begin
			@(negedge clock_i);
			h = tx_ready;
			@(posedge clock_i);
			if (h) break;
		end
		valid <= 1'b0;
		if (i == 3000) tmo();
		for (i = 0; i < 3000; i++) begin
			@(negedge clock_i);
			if (tx_ready === 1'b1) break;
		end
		if (i == 3000) tmo();
	endtask : send
	// wait for an arrival on receiver s and check the character
	task automatic wstb(input int s, input logic [7:0] e);
		int i;
		for (i = 0; i < 3000; i++) begin
			@(negedge clock_i);
			if (stb[s] === 1'b1) break;
		end
		if (i == 3000) tmo();
		@(negedge clock_i);
		cmp32("char", {24'h0, e}, {24'h0, chr[s]});
	endtask : wstb
	// hand-made frame on the faulty link: lead, 8 bits, check bit, end bit
	task automatic raw(input logic [7:0] d, input logic p, input logic e);
		logic [10:0] b;
		b = {e, p, d, 1'b0};
		for (int j = 0; j < 11; j++) begin
			lnk[1].serial_in_pin <= b[j];
			repeat (BT) @(posedge clock_i);
		end
	endtask : raw
	// main sequence
	initial begin
		int m;
		logic [7:0] ex; // character expected at the receiver
		data = 8'h00;
		valid = 1'b0;
		cfg = 5'h00;
		{awaddr, araddr, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		lnk[1].serial_in_pin = 1'b1;
		repeat (5) @(posedge clock_i);
		rst_i <= 1'b0;
		// reset values, unmapped and read-only places
		axr("mode", 0, `UAFR_REG_MODE, 32'h0, `UAFR_RESP_OKAY);
		axr("div", 0, `UAFR_REG_DIV, 32'h0, `UAFR_RESP_OKAY);
		axr("status", 0, `UAFR_REG_STATUS, 32'h0, `UAFR_RESP_OKAY);
		axr("mask", 0, `UAFR_REG_MASK, 32'h0, `UAFR_RESP_OKAY);
		axr("unmapped", 0, 8'h20, 32'h0, `UAFR_RESP_SLVERR);
		axw(8'h20, 32'hFFFF_FFFF, `UAFR_RESP_SLVERR);
		axw(`UAFR_REG_DATA, 32'h0000_00FF, `UAFR_RESP_OKAY);
		axw(`UAFR_REG_DIV, 32'h0000_0001, `UAFR_RESP_OKAY);
		axr("div", 0, `UAFR_REG_DIV, 32'h1, `UAFR_RESP_OKAY);
		cmp1("irq", 1'b0, irq[0]);
		// six frame formats in turn, from cfgs
		for (m = 0; m < 6; m++) begin
			cfg <= cfgs[m];
			axw(`UAFR_REG_MODE, {26'h0, cfgs[m], 1'b1}, `UAFR_RESP_OKAY);
			// seven-bit characters arrive right-aligned with bit 7 clear
			ex = cfgs[m][0] ? {1'b0, chs[m][6:0]} : chs[m];
			fork
				send(chs[m]);
				wstb(0, ex);
			join
			axr("status", 0, `UAFR_REG_STATUS, 32'h1, `UAFR_RESP_OKAY);
			axw(`UAFR_REG_STATUS, 32'hF, `UAFR_RESP_OKAY);
		end
		// interrupt raised, masked and cleared
		axw(`UAFR_REG_MASK, 32'h1, `UAFR_RESP_OKAY);
		fork
			send(8'h5C);
			wstb(0, 8'h5C);
		join
		cmp1("irq", 1'b1, irq[0]);
		axw(`UAFR_REG_MASK, 32'h0, `UAFR_RESP_OKAY);
		cmp1("irq", 1'b0, irq[0]);
		axw(`UAFR_REG_MASK, 32'h1, `UAFR_RESP_OKAY);
		axw(`UAFR_REG_STATUS, 32'h1, `UAFR_RESP_OKAY);
		cmp1("irq", 1'b0, irq[0]);
		axw(`UAFR_REG_MASK, 32'h0, `UAFR_RESP_OKAY);
		// back-to-back frames with two end bits
		cfg <= 5'h08;
		axw(`UAFR_REG_MODE, 32'h11, `UAFR_RESP_OKAY);
		fork
			begin
				send(8'h12);
				send(8'h34);
			end
			begin
				wstb(0, 8'h12);
				wstb(0, 8'h34);
			end
		join
		axr("status", 0, `UAFR_REG_STATUS, 32'h9, `UAFR_RESP_OKAY);
		// faulty sender: wrong check bit, then low end bit
		axw(`UAFR_REG_MODE, 32'h05, `UAFR_RESP_OKAY);
		axw(`UAFR_REG_STATUS, 32'hF, `UAFR_RESP_OKAY);
		fork
			raw(8'h03, 1'b1, 1'b1);
			wstb(1, 8'h03);
		join
		axr("status", 1, `UAFR_REG_STATUS, 32'h3, `UAFR_RESP_OKAY);
		axw(`UAFR_REG_STATUS, 32'hF, `UAFR_RESP_OKAY);
		fork
			begin
				raw(8'h03, 1'b0, 1'b0);
				lnk[1].serial_in_pin <= 1'b1;
			end
			wstb(1, 8'h03);
		join
		axr("status", 1, `UAFR_REG_STATUS, 32'h5, `UAFR_RESP_OKAY);
		// short low tail after the bad end bit is high at mid-bit: a glitch, no frame
		repeat (400) @(posedge clock_i);
		axr("status", 1, `UAFR_REG_STATUS, 32'h5, `UAFR_RESP_OKAY);
		axr("data", 1, `UAFR_REG_DATA, 32'h3, `UAFR_RESP_OKAY);
		// second end position low starts the next frame
		axw(`UAFR_REG_MODE, 32'h15, `UAFR_RESP_OKAY);
		axw(`UAFR_REG_STATUS, 32'hF, `UAFR_RESP_OKAY);
		fork
			begin
				raw(8'h11, 1'b0, 1'b1);
				raw(8'h22, 1'b0, 1'b1);
			end
			begin
				wstb(1, 8'h11);
				wstb(1, 8'h22);
			end
		join
		axr("status", 1, `UAFR_REG_STATUS, 32'h9, `UAFR_RESP_OKAY);
		end_sim();
	end
endmodule : test_uart_async_frame_receiver
